//--- dct_consts.svh
// timing counts, pin codes and field positions for the DDR command timer
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH

// ==========================================================
// clocking
`define DCT_CLK_NS        50
`define DCT_CK_DIV        4
`define DCT_TCK_NS        (`DCT_CLK_NS * `DCT_CK_DIV)
`define DCT_CEIL_TCK(ns)  (((ns) + `DCT_TCK_NS - 1) / `DCT_TCK_NS)
`define DCT_QPH_ISSUE     2'h1

// ==========================================================
// memory timing, in printed units
`define DCT_MRD_TCK       2
`define DCT_XSRD_TCK      200
`define DCT_XSNR_NS       80
`define DCT_RFC_NS        80
`define DCT_WR_NS         15
`define DCT_RP_NS         20
// 7.8 us, held in tenths of a microsecond
`define DCT_REFI_TENTH_US 78
`define DCT_MAX_POSTED    8

// ==========================================================
// derived counts in memory clock periods; read window in clock cycles
`define DCT_RP_TCK        `DCT_CEIL_TCK(`DCT_RP_NS)
`define DCT_RFC_TCK       `DCT_CEIL_TCK(`DCT_RFC_NS)
`define DCT_DAL_TCK       (`DCT_CEIL_TCK(`DCT_WR_NS) + `DCT_RP_TCK)
`define DCT_XSNR_MIN_TCK  `DCT_CEIL_TCK(`DCT_XSNR_NS)
`define DCT_XSNR_TCK      ((`DCT_XSNR_MIN_TCK > `DCT_RFC_TCK + 1) ? \
	`DCT_XSNR_MIN_TCK : (`DCT_RFC_TCK + 1))
`define DCT_REFI_TCK      ((`DCT_REFI_TENTH_US * 100) / `DCT_TCK_NS)
`define DCT_WR_GAP_TCK    3
`define DCT_RD_GAP_TCK    3
`define DCT_RD_WINDOW     6'h28

// ==========================================================
// write strobe schedule, clock cycles after the issue edge
`define DCT_WS_PRE        4'h5
`define DCT_WS_DQ0        4'h6
`define DCT_WS_RISE       4'h7
`define DCT_WS_DQ1        4'h8
`define DCT_WS_FALL       4'h9
`define DCT_WS_END        4'hA

// ==========================================================
// command pins {ras_n, cas_n, we_n} and address fields
`define DCT_PIN_NOP       3'h7
`define DCT_PIN_ACT       3'h3
`define DCT_PIN_RD        3'h5
`define DCT_PIN_WR        3'h4
`define DCT_PIN_PRE       3'h2
`define DCT_PIN_REF       3'h1
`define DCT_PIN_MRS       3'h0
`define DCT_AP_BIT        10
`define DCT_EMRS_BANK     2'h1
`define DCT_MRS_BANK      2'h0

`endif

//--- dct_pkg.sv
// types shared by the DDR command timer
package dct_pkg;
	typedef enum logic [3:0] {
		DCT_OP_ACT, DCT_OP_RD, DCT_OP_WR, DCT_OP_WRA, DCT_OP_PRE,
		DCT_OP_MRS, DCT_OP_SRE, DCT_OP_SRX, DCT_OP_INIT
	} dct_op_e;
	typedef enum logic [2:0] {
		DCT_ST_INIT_HOLD, DCT_ST_INIT_SEQ, DCT_ST_IDLE,
		DCT_ST_SELFREF, DCT_ST_ERROR
	} dct_state_e;
endpackage

//--- dct_down_counter.sv
// loadable down counter ticking once per memory clock period
`timescale 1ns/1ns
module dct_down_counter #(
	parameter int           W       = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// system
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         ce,
	// control
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	// status
	output logic              done
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt;
		if (load) begin
			next_cnt = loadVal;
		end else if (tick && cnt != '0) begin
			next_cnt = cnt - W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			cnt <= RST_VAL;
		end else if (ce) begin
			cnt <= next_cnt;
		end
	end

	assign done = (cnt == '0);
endmodule

//--- dct_sync2.sv
// two-flop synchroniser for pins from the memory
`timescale 1ns/1ns
module dct_sync2 #(
	parameter int W = 1
) (
	// system
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         ce,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			meta <= '0;
			q    <= '0;
		end else if (ce) begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule

//--- dct_ctrl.sv
// host-side DDR command timer: sequencing, refresh, write strobe, read capture
// Summary of operation
// [R1] no command within two periods after mode set
// [R2] reads wait 200 periods after self-refresh exit
// [R3] other commands wait exit delay after self-refresh
// [R4] refresh every interval, at most eight posted
// [R5] auto-precharge recovery: ceil(wr)+ceil(rp) periods
// [R6] first write strobe rise one period after command
// [R7] memory drives read preamble low about one period
// [R8] memory holds read postamble low about half period
// [R9] write preamble held low half a period
// [R10] strobe goes from released to low first
// [R11] write postamble low half a period, then release
// [R12] memory tolerates longer write postamble
// [R13] strobe high and low phases half a period
// [R14] strobe falls midway between clock rises
// [R15] memory output drive follows access windows
// [R16] illegal operation forces power down and reinit
// [R17] clock changes allowed only in self refresh
// [R18] exit delay covered by refresh cycle plus one
// [R19] refresh overrun marks stored data suspect
// [R20] nanosecond times rounded up, enforced by counters
`timescale 1ns/1ns
`include "dct_consts.svh"
module dct_ctrl #(
	parameter int            DW            = 8,
	parameter int            AW            = 13,
	parameter int            BANKS         = 4,
	parameter int            INIT_HOLD_TCK = 200,
	parameter logic [AW-1:0] INIT_EMRS     = 13'h0000,
	parameter logic [AW-1:0] INIT_MRS      = 13'h0021
) (
	// system
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire logic                ce,
	// user command
	input  wire logic                cmdValid,
	input  wire dct_pkg::dct_op_e    cmdOp,
	input  wire logic [1:0]          cmdBank,
	input  wire logic [AW-1:0]       cmdAddr,
	input  wire logic [2*DW-1:0]     cmdWrData,
	output logic                     cmdReady,
	// user status
	output logic                     rdValid,
	output logic      [2*DW-1:0]     rdData,
	output logic                     ready,
	output logic                     needInit,
	output logic                     dataSuspect,
	output logic                     ckChangeOk,
	output logic      [3:0]          refreshPosted,
	// memory pins
	output logic                     ck,
	output logic                     ckN,
	output logic                     cke,
	output logic                     csN,
	output logic                     rasN,
	output logic                     casN,
	output logic                     weN,
	output logic      [1:0]          ba,
	output logic      [AW-1:0]       addr,
	output logic      [DW-1:0]       dqOut,
	output logic                     dqOeN,
	input  wire logic [DW-1:0]       dqIn,
	output logic                     dqsOut,
	output logic                     dqsOeN,
	input  wire logic                dqsIn
);
	localparam logic [AW-1:0] AP_MASK = AW'(1) << `DCT_AP_BIT;
	localparam int            XSRD    = `DCT_XSRD_TCK;
	localparam int            XSNR    = `DCT_XSNR_TCK;
	localparam int            DAL     = `DCT_DAL_TCK;
	localparam int            MAXP    = `DCT_MAX_POSTED;

	// ==========================================================
	// state
	logic [1:0]          qph, next_qph;
	dct_pkg::dct_state_e state, next_state;
	logic                next_cke;
	logic [2:0]          pins, next_pins;
	logic [1:0]          next_ba;
	logic [AW-1:0]       next_addr;
	logic [2:0]          initStep, next_initStep;
	logic [3:0]          posted, next_posted;
	logic                next_suspect;
	logic                slot, gapDone, gapLoad, xsrdDone, xsrdLoad;
	logic [7:0]          gapVal;
	logic                refDone, refTick, refEvent, refIssue;
	logic [BANKS-1:0]    dalDone, dalLoad;
	logic                opOk, issueWr, issueRd;

	// ==========================================================
	// memory clock divider and pin mapping
	assign slot          = (qph == `DCT_QPH_ISSUE);
	assign ck            = ~qph[1];
	assign ckN           = qph[1];
	assign rasN          = pins[2];
	assign casN          = pins[1];
	assign weN           = pins[0];
	assign ready         = (state == dct_pkg::DCT_ST_IDLE);
	assign needInit      = (state == dct_pkg::DCT_ST_ERROR);
	assign ckChangeOk    = (state == dct_pkg::DCT_ST_SELFREF); // [R17]
	assign refreshPosted = posted;
	assign refTick       = slot && (state == dct_pkg::DCT_ST_IDLE);
	assign refEvent      = refTick && refDone;

	// ==========================================================
	// timing counters, counts rounded up to whole periods, refresh interval rounded down
	dct_down_counter #(.W(8), .RST_VAL(8'(INIT_HOLD_TCK - 1))) u_gap ( // [R20]
		.clock(clock), .rstn(rstn), .ce(ce), .tick(slot),
		.load(gapLoad), .loadVal(gapVal), .done(gapDone));
	dct_down_counter #(.W(8), .RST_VAL(8'h00)) u_xsrd ( // [R2]
		.clock(clock), .rstn(rstn), .ce(ce), .tick(slot),
		.load(xsrdLoad), .loadVal(8'(`DCT_XSRD_TCK - 1)), .done(xsrdDone));
	dct_down_counter #(.W(8), .RST_VAL(8'(`DCT_REFI_TCK - 1))) u_refi (
		.clock(clock), .rstn(rstn), .ce(ce), .tick(refTick),
		.load(refEvent), .loadVal(8'(`DCT_REFI_TCK - 1)), // [R4]
		.done(refDone));
	for (genvar b = 0; b < BANKS; b++) begin : g_dal
		dct_down_counter #(.W(8), .RST_VAL(8'h00)) u_dal ( // [R5]
			.clock(clock), .rstn(rstn), .ce(ce), .tick(slot),
			.load(dalLoad[b]),
			.loadVal(8'(`DCT_DAL_TCK + `DCT_WR_GAP_TCK - 1)),
			.done(dalDone[b]));
	end

	// ==========================================================
	// command sequencer
	always_comb begin
		unique case (cmdOp)
			dct_pkg::DCT_OP_ACT: opOk = dalDone[cmdBank]; // [R5]
			dct_pkg::DCT_OP_RD:  opOk = xsrdDone; // [R2]
			default:             opOk = 1'b1;
		endcase
	end

	always_comb begin
		next_qph      = qph + 2'h1;
		next_state    = state;
		next_cke      = cke;
		next_pins     = pins;
		next_ba       = ba;
		next_addr     = addr;
		next_initStep = initStep;
		next_suspect  = dataSuspect;
		gapLoad       = 1'b0;
		gapVal        = 8'h00;
		xsrdLoad      = 1'b0;
		dalLoad       = '0;
		refIssue      = 1'b0;
		issueWr       = 1'b0;
		issueRd       = 1'b0;
		cmdReady      = 1'b0;
		if (slot) begin
			next_pins = `DCT_PIN_NOP;
			unique case (state)
				dct_pkg::DCT_ST_INIT_HOLD: begin
					next_cke = 1'b0;
					if (gapDone) begin
						next_cke      = 1'b1;
						next_state    = dct_pkg::DCT_ST_INIT_SEQ;
						next_initStep = 3'h0;
					end
				end
				dct_pkg::DCT_ST_INIT_SEQ: begin
					if (gapDone) begin
						next_initStep = initStep + 3'h1;
						gapLoad       = 1'b1;
						if (initStep == 3'h0) begin
							next_pins = `DCT_PIN_PRE;
							next_addr = AP_MASK;
							gapVal    = 8'(`DCT_RP_TCK - 1);
						end else if (initStep == 3'h1) begin
							next_pins = `DCT_PIN_MRS;
							next_ba   = `DCT_EMRS_BANK;
							next_addr = INIT_EMRS;
							gapVal    = 8'(`DCT_MRD_TCK - 1); // [R1]
						end else if (initStep == 3'h2) begin
							next_pins = `DCT_PIN_MRS;
							next_ba   = `DCT_MRS_BANK;
							next_addr = INIT_MRS;
							gapVal    = 8'(`DCT_MRD_TCK - 1); // [R1]
						end else if (initStep < 3'h5) begin
							next_pins = `DCT_PIN_REF;
							gapVal    = 8'(`DCT_RFC_TCK - 1);
						end else begin
							next_state = dct_pkg::DCT_ST_IDLE;
						end
					end
				end
				dct_pkg::DCT_ST_IDLE: begin
					if (gapDone && posted == 4'(`DCT_MAX_POSTED)) begin
						next_pins = `DCT_PIN_REF; // [R4]
						refIssue  = 1'b1;
						gapLoad   = 1'b1;
						gapVal    = 8'(`DCT_RFC_TCK - 1);
					end else if (gapDone && cmdValid && opOk) begin
						cmdReady  = 1'b1;
						gapLoad   = 1'b1;
						next_ba   = cmdBank;
						next_addr = cmdAddr;
						unique case (cmdOp)
							dct_pkg::DCT_OP_ACT: begin
								next_pins = `DCT_PIN_ACT;
							end
							dct_pkg::DCT_OP_RD: begin
								next_pins = `DCT_PIN_RD;
								gapVal    = 8'(`DCT_RD_GAP_TCK - 1);
								issueRd   = 1'b1;
							end
							dct_pkg::DCT_OP_WR: begin
								next_pins = `DCT_PIN_WR;
								next_addr = cmdAddr & ~AP_MASK;
								gapVal    = 8'(`DCT_WR_GAP_TCK - 1);
								issueWr   = 1'b1;
							end
							dct_pkg::DCT_OP_WRA: begin
								next_pins = `DCT_PIN_WR;
								next_addr = cmdAddr | AP_MASK;
								gapVal    = 8'(`DCT_WR_GAP_TCK - 1);
								issueWr   = 1'b1;
								dalLoad   = BANKS'(1) << cmdBank; // [R5]
							end
							dct_pkg::DCT_OP_PRE: begin
								next_pins = `DCT_PIN_PRE;
								gapVal    = 8'(`DCT_RP_TCK - 1); // [R20]
							end
							dct_pkg::DCT_OP_MRS: begin
								next_pins = `DCT_PIN_MRS;
								gapVal    = 8'(`DCT_MRD_TCK - 1); // [R1]
							end
							dct_pkg::DCT_OP_SRE: begin
								next_pins  = `DCT_PIN_REF;
								next_cke   = 1'b0;
								next_state = dct_pkg::DCT_ST_SELFREF;
							end
							default: begin
								next_state   = dct_pkg::DCT_ST_ERROR; // [R16]
								next_cke     = 1'b0;
								next_suspect = 1'b1;
							end
						endcase
					end else if (gapDone && !cmdValid && posted != 4'h0) begin
						next_pins = `DCT_PIN_REF;
						refIssue  = 1'b1;
						gapLoad   = 1'b1;
						gapVal    = 8'(`DCT_RFC_TCK - 1);
					end
				end
				dct_pkg::DCT_ST_SELFREF: begin
					if (cmdValid) begin
						cmdReady = 1'b1;
						if (cmdOp == dct_pkg::DCT_OP_SRX) begin
							next_cke   = 1'b1;
							next_state = dct_pkg::DCT_ST_IDLE;
							gapLoad    = 1'b1;
							gapVal     = 8'(`DCT_XSNR_TCK - 1); // [R3] [R18]
							xsrdLoad   = 1'b1; // [R2]
						end else begin
							next_state   = dct_pkg::DCT_ST_ERROR; // [R16]
							next_suspect = 1'b1;
						end
					end
				end
				dct_pkg::DCT_ST_ERROR: begin
					next_cke = 1'b0; // [R16]
					if (cmdValid && cmdOp == dct_pkg::DCT_OP_INIT) begin
						cmdReady   = 1'b1;
						next_state = dct_pkg::DCT_ST_INIT_HOLD;
						gapLoad    = 1'b1;
						gapVal     = 8'(INIT_HOLD_TCK - 1);
					end
				end
			endcase
		end
		next_posted = posted;
		if (state == dct_pkg::DCT_ST_INIT_SEQ) begin
			next_posted = 4'h0;
		end else if (refEvent && !refIssue) begin
			if (posted == 4'(`DCT_MAX_POSTED)) begin
				next_suspect = 1'b1; // [R19]
			end else begin
				next_posted = posted + 4'h1;
			end
		end else if (!refEvent && refIssue) begin
			next_posted = posted - 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			qph         <= 2'h0;
			state       <= dct_pkg::DCT_ST_INIT_HOLD;
			cke         <= 1'b0;
			csN         <= 1'b1;
			pins        <= `DCT_PIN_NOP;
			ba          <= 2'h0;
			addr        <= '0;
			initStep    <= 3'h0;
			posted      <= 4'h0;
			dataSuspect <= 1'b0;
		end else if (ce) begin
			qph         <= next_qph;
			state       <= next_state;
			cke         <= next_cke;
			csN         <= 1'b0;
			pins        <= next_pins;
			ba          <= next_ba;
			addr        <= next_addr;
			initStep    <= next_initStep;
			posted      <= next_posted;
			dataSuspect <= next_suspect;
		end
	end

	// ==========================================================
	// write strobe and data
	logic [3:0]      wstep, next_wstep;
	logic [2*DW-1:0] wrWord, next_wrWord;
	logic            next_dqsOut, next_dqsOeN, next_dqOeN;
	logic [DW-1:0]   next_dqOut;

	always_comb begin
		next_wrWord = issueWr ? cmdWrData : wrWord;
		if (wstep != 4'h0 && wstep != `DCT_WS_END) begin
			next_wstep = wstep + 4'h1;
		end else begin
			next_wstep = issueWr ? 4'h1 : 4'h0;
		end
		// released, preamble low, one pulse, postamble low
		next_dqsOeN = !(next_wstep >= `DCT_WS_PRE && // [R10] [R9] [R11]
			next_wstep <= `DCT_WS_END);
		next_dqsOut = (next_wstep >= `DCT_WS_RISE && // [R6] [R13] [R14]
			next_wstep < `DCT_WS_FALL);
		next_dqOeN  = !(next_wstep >= `DCT_WS_DQ0 &&
			next_wstep <= `DCT_WS_FALL);
		next_dqOut  = '0;
		if (next_wstep >= `DCT_WS_DQ0 && next_wstep < `DCT_WS_DQ1) begin
			next_dqOut = wrWord[DW-1:0];
		end else if (next_wstep >= `DCT_WS_DQ1 &&
			next_wstep <= `DCT_WS_FALL) begin
			next_dqOut = wrWord[2*DW-1:DW];
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wstep  <= 4'h0;
			wrWord <= '0;
			dqsOut <= 1'b0;
			dqsOeN <= 1'b1;
			dqOeN  <= 1'b1;
			dqOut  <= '0;
		end else if (ce) begin
			wstep  <= next_wstep;
			wrWord <= next_wrWord;
			dqsOut <= next_dqsOut;
			dqsOeN <= next_dqsOeN;
			dqOeN  <= next_dqOeN;
			dqOut  <= next_dqOut;
		end
	end

	// ==========================================================
	// read capture on synchronised strobe edges
	logic [DW:0]   rdSync;
	logic [1:0]    rdPhase, next_rdPhase;
	logic [5:0]    rdArm, next_rdArm;
	logic [DW-1:0] rdLo, next_rdLo;
	logic          next_rdValid;
	logic [2*DW-1:0] next_rdData;

	dct_sync2 #(.W(DW + 1)) u_rdsync (
		.clock(clock), .rstn(rstn), .ce(ce),
		.d({dqsIn, dqIn}), .q(rdSync));

	always_comb begin
		next_rdLo    = rdLo;
		next_rdData  = rdData;
		next_rdValid = 1'b0;
		next_rdPhase = rdPhase;
		next_rdArm   = (rdArm != 6'h00) ? rdArm - 6'h01 : 6'h00;
		// released strobe may sit at either level: wait for preamble low
		if (rdArm != 6'h00 && rdPhase == 2'h0 && !rdSync[DW]) begin
			next_rdPhase = 2'h1;
		end
		if (rdArm != 6'h00 && rdPhase == 2'h1 && rdSync[DW]) begin
			next_rdLo    = rdSync[DW-1:0];
			next_rdPhase = 2'h2;
		end
		if (rdArm != 6'h00 && rdPhase == 2'h2 && !rdSync[DW]) begin
			next_rdData  = {rdSync[DW-1:0], rdLo};
			next_rdValid = 1'b1;
			next_rdArm   = 6'h00;
			next_rdPhase = 2'h0;
		end
		if (issueRd) begin
			next_rdArm   = `DCT_RD_WINDOW;
			next_rdPhase = 2'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			rdPhase <= 2'h0;
			rdArm   <= 6'h00;
			rdLo    <= '0;
			rdData  <= '0;
			rdValid <= 1'b0;
		end else if (ce) begin
			rdPhase <= next_rdPhase;
			rdArm   <= next_rdArm;
			rdLo    <= next_rdLo;
			rdData  <= next_rdData;
			rdValid <= next_rdValid;
		end
	end

	// ==========================================================
	// checks
	logic [7:0] sinceSrx, sinceWra;
	logic [1:0] wraBank;
	logic       isRd, isWr, isAct, isMrs;
	assign isRd  = !csN && pins == `DCT_PIN_RD;
	assign isWr  = !csN && pins == `DCT_PIN_WR;
	assign isAct = !csN && pins == `DCT_PIN_ACT;
	assign isMrs = !csN && pins == `DCT_PIN_MRS;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			sinceSrx <= 8'hFF;
			sinceWra <= 8'hFF;
			wraBank  <= 2'h0;
		end else if (ce && qph == 2'h2) begin
			if (cke && !$past(cke) && $past(ckChangeOk)) begin
				sinceSrx <= 8'h01;
			end else if (sinceSrx != 8'hFF) begin
				sinceSrx <= sinceSrx + 8'h01;
			end
			if (isWr && addr[`DCT_AP_BIT]) begin
				sinceWra <= 8'h01;
				wraBank  <= ba;
			end else if (sinceWra != 8'hFF) begin
				sinceWra <= sinceWra + 8'h01;
			end
		end
	end

	default clocking dct_cb @(posedge clock iff ce);
	endclocking
	default disable iff (!rstn);

	a_mode_gap: assert property ((qph == 2'h2 && isMrs) |-> // [R1]
		##4 (pins == `DCT_PIN_NOP)) else $error("command too soon after mode set");
	a_read_after_srx: assert property ((qph == 2'h2 && isRd) |-> // [R2]
		sinceSrx >= XSRD) else $error("read too soon after self refresh");
	a_other_after_srx: assert property ((qph == 2'h2 && !isRd && // [R3]
		pins != `DCT_PIN_NOP) |-> sinceSrx >= XSNR)
		else $error("command too soon after self refresh");
	a_posted_limit: assert property (posted <= 4'(MAXP)) // [R4]
		else $error("too many posted refreshes");
	a_dal_gap: assert property ((qph == 2'h2 && isAct && ba == wraBank) // [R5]
		|-> sinceWra >= DAL) else $error("activate inside write recovery");
	a_first_edge: assert property ((qph == 2'h0 && isWr) |-> // [R6]
		##4 ($rose(dqsOut) && !dqsOeN)) else $error("strobe rise misplaced");
	a_wr_preamble: assert property ((qph == 2'h0 && isWr) |-> // [R9]
		##2 (!dqsOeN && !dqsOut) [*2]) else $error("write preamble short");
	a_strobe_valid: assert property ($fell(dqsOeN) |-> !dqsOut) // [R10]
		else $error("strobe not low when driven");
	a_wr_postamble: assert property (($fell(dqsOut) && !dqsOeN) |-> // [R11]
		(!dqsOut && !dqsOeN) [*2] ##1 dqsOeN) else $error("bad postamble");
	a_strobe_width: assert property ($rose(dqsOut) |-> // [R13]
		dqsOut [*2] ##1 !dqsOut) else $error("strobe high width wrong");
	a_fall_centre: assert property (($fell(dqsOut) && !dqsOeN) |-> // [R14]
		qph == 2'h2) else $error("strobe fall off centre");
	a_illegal_error: assert property ((cmdReady && // [R16]
		state == dct_pkg::DCT_ST_SELFREF && cmdOp != dct_pkg::DCT_OP_SRX)
		|=> (state == dct_pkg::DCT_ST_ERROR && !cke))
		else $error("illegal op not trapped");
	a_freq_change: assert property (ckChangeOk |-> !cke) // [R17]
		else $error("clock change window with clock enabled");

	c_write: cover property ($rose(dqsOut) ##2 !dqsOut);
	c_read: cover property (rdValid);
	c_srx: cover property (qph == 2'h2 && sinceSrx == 8'h01);
	c_error: cover property (needInit);
endmodule

//--- dct_mem_model.sv
// behavioural memory device facing the command timer
`timescale 1ns/1ns
`include "dct_consts.svh"
module dct_mem_model (
	// memory pins
	input  wire logic       ck,
	input  wire logic       csN,
	input  wire logic [2:0] pins,
	input  wire logic [1:0] ba,
	input  wire logic [7:0] dq,
	input  wire logic       dqs,
	// device drive
	output logic      [7:0] devDq,
	output logic            devDqOeN,
	output logic            devDqs,
	output logic            devDqsOeN,
	output int              violations
);
	logic [15:0] store [4];
	logic [7:0]  lo;
	logic [1:0]  wb;
	logic [1:0]  rb;
	int          mrsGap = 9;
	time         write_recovery_time;
	wire         isCmd = !csN && pins != `DCT_PIN_NOP;
	initial begin
		devDqOeN = 1;
		devDqsOeN = 1;
		devDqs = 0;
		devDq = 8'h00;
		violations = 0;
		foreach (store[i]) store[i] = 16'h0000;
	end
	// ==========================================================
	// spacing after mode set
	always @(posedge ck) begin
		mrsGap++;
		if (isCmd && mrsGap < `DCT_MRD_TCK) violations++;
		if (isCmd && pins == `DCT_PIN_MRS) mrsGap = 0;
	end
	// ==========================================================
	// write burst; no limit on postamble length
	always @(posedge ck) begin
		if (isCmd && pins == `DCT_PIN_WR) begin
			write_recovery_time = $time;
			wb = ba;
			@(posedge dqs);
			if ($time - write_recovery_time < 3 * `DCT_TCK_NS / 4) violations++;
			if ($time - write_recovery_time > 5 * `DCT_TCK_NS / 4) violations++;
			lo = dq;
			@(negedge dqs);
			store[wb] = {dq, lo};
		end
	end
	// ==========================================================
	// read burst, latency two periods
	always @(posedge ck) begin
		if (isCmd && pins == `DCT_PIN_RD) begin
			rb = ba;
			@(posedge ck);
			devDqsOeN = 0;
			devDqs = 0;
			@(posedge ck);
			devDqOeN = 0;
			devDq = store[rb][7:0];
			devDqs = 1;
			@(negedge ck);
			devDq = store[rb][15:8];
			devDqs = 0;
			@(posedge ck);
			devDqOeN = 1;
			devDqsOeN = 1;
		end
	end
endmodule

//--- ddr_sdram_command_timing_tb_top.sv
// self-checking bench for the DDR command timer
`timescale 1ns/1ns
`include "dct_consts.svh"
module ddr_sdram_command_timing_tb_top;
	logic              clock = 0;
	logic              rstn = 0;
	logic              ce = 1;
	logic              cmdValid = 0;
	dct_pkg::dct_op_e  cmdOp = dct_pkg::DCT_OP_ACT;
	logic [1:0]        cmdBank = 2'h0;
	logic [15:0]       cmdWrData = 16'h0000;
	logic              cmdReady, rdValid, ready, needInit, dataSuspect;
	logic              ckChangeOk, ck, ckN, cke, csN, rasN, casN, weN;
	logic [15:0]       rdData;
	logic [3:0]        refreshPosted;
	logic [1:0]        ba;
	logic [12:0]       addr;
	logic [7:0]        dqOut, devDq;
	logic              dqOeN, dqsOut, dqsOeN, devDqOeN, devDqs, devDqsOeN;
	logic              dqLast = 1'b0;
	logic              dqsLast = 1'b0;
	wire  [7:0]        dqW;
	wire               dqsW;
	int                violations, errors = 0, n_compared = 0, cyc = 0;
	int                t0, t1, t2;

	initial forever #25 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	// ==========================================================
	// released strobe shows the inverse of its last level, data lines the inverse of bit 0's
	always @* begin
		if (dqsOeN === 1'b0)
			dqsLast = dqsOut;
		else if (devDqsOeN === 1'b0)
			dqsLast = devDqs;
		if (dqOeN === 1'b0)
			dqLast = dqOut[0];
		else if (devDqOeN === 1'b0)
			dqLast = devDq[0];
	end
	assign dqsW = (dqsOeN === 1'b0) ? dqsOut :
		(devDqsOeN === 1'b0) ? devDqs : ~dqsLast;
	assign dqW = (dqOeN === 1'b0) ? dqOut :
		(devDqOeN === 1'b0) ? devDq : {8{~dqLast}};

	dct_ctrl #(.INIT_HOLD_TCK(2)) uut (.clock(clock), .rstn(rstn),
		.ce(ce), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdBank(cmdBank),
		.cmdAddr(13'h0021), .cmdWrData(cmdWrData), .cmdReady(cmdReady),
		.rdValid(rdValid), .rdData(rdData), .ready(ready),
		.needInit(needInit), .dataSuspect(dataSuspect),
		.ckChangeOk(ckChangeOk), .refreshPosted(refreshPosted), .ck(ck),
		.ckN(ckN), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
		.weN(weN), .ba(ba), .addr(addr), .dqOut(dqOut), .dqOeN(dqOeN),
		.dqIn(dqW), .dqsOut(dqsOut), .dqsOeN(dqsOeN), .dqsIn(dqsW));
	dct_mem_model mem (.ck(ck), .csN(csN), .pins({rasN, casN, weN}),
		.ba(ba), .dq(dqW), .dqs(dqsW), .devDq(devDq), .devDqOeN(devDqOeN),
		.devDqs(devDqs), .devDqsOeN(devDqsOeN), .violations(violations));

	// ==========================================================
	// shared tasks
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
		input bit atLeast);
		n_compared++;
		if (atLeast ? ((got >= exp) !== 1'b1) : (got !== exp)) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic issue(input dct_pkg::dct_op_e op, input logic [1:0] bk,
		input logic [15:0] wd, output int at);
		int n;
		@(negedge clock);
		cmdValid = 1;
		cmdOp = op;
		cmdBank = bk;
		cmdWrData = wd;
		#1;
		for (n = 0; n < 2000 && cmdReady !== 1'b1; n++) begin
			@(negedge clock);
			#1;
		end
		if (n == 2000) begin
			errors++;
			close_out();
		end
		at = cyc;
		@(negedge clock);
		cmdValid = 0;
	endtask
	task automatic wait_flag(input bit rd, input logic [15:0] exp);
		int n;
		for (n = 0; n < 2000 && (rd ? rdValid : ready) !== 1'b1; n++)
			@(negedge clock);
		if (n == 2000 || (rd && n > 80)) begin
			errors++;
			close_out();
		end
		if (rd)
			cmp(rdData, exp, 0);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_write_read;
		issue(dct_pkg::DCT_OP_MRS, 2'h0, 16'h0000, t0);
		issue(dct_pkg::DCT_OP_WR, 2'h1, 16'hC33C, t1);
		cmp(16'(t1 - t0), 16'(`DCT_MRD_TCK * `DCT_CK_DIV), 1);
		issue(dct_pkg::DCT_OP_WR, 2'h2, 16'h5AA5, t2);
		issue(dct_pkg::DCT_OP_RD, 2'h1, 16'h0000, t0);
		wait_flag(1, 16'hC33C);
		issue(dct_pkg::DCT_OP_RD, 2'h2, 16'h0000, t0);
		wait_flag(1, 16'h5AA5);
		cmp({15'h0, dqsOeN}, 16'h0001, 0);
		$display("write and read back done");
	endtask
	task automatic t_recovery;
		issue(dct_pkg::DCT_OP_WRA, 2'h3, 16'h0FF0, t0);
		issue(dct_pkg::DCT_OP_ACT, 2'h3, 16'h0000, t1);
		cmp(16'(t1 - t0), 16'((`DCT_DAL_TCK + 3) * `DCT_CK_DIV), 1);
		$display("auto-precharge recovery done");
	endtask
	task automatic t_self_refresh;
		issue(dct_pkg::DCT_OP_SRE, 2'h0, 16'h0000, t0);
		t1 = ck;
		ce = 0;
		repeat (8) @(negedge clock);
		cmp({13'h0, ck == t1[0], ckChangeOk, cke}, 16'h0006, 0);
		ce = 1;
		issue(dct_pkg::DCT_OP_SRX, 2'h0, 16'h0000, t0);
		issue(dct_pkg::DCT_OP_ACT, 2'h1, 16'h0000, t1);
		cmp(16'(t1 - t0), 16'(`DCT_XSNR_TCK * `DCT_CK_DIV), 1);
		issue(dct_pkg::DCT_OP_RD, 2'h1, 16'h0000, t2);
		cmp(16'(t2 - t0), 16'(`DCT_XSRD_TCK * `DCT_CK_DIV), 1);
		wait_flag(1, 16'hC33C);
		cmp(16'h0008, {12'h0, refreshPosted}, 1);
		$display("self refresh done");
	endtask
	task automatic t_illegal;
		issue(dct_pkg::DCT_OP_SRE, 2'h0, 16'h0000, t0);
		issue(dct_pkg::dct_op_e'(4'h9), 2'h0, 16'h0000, t0);
		repeat (8) @(negedge clock);
		cmp({13'h0, needInit, dataSuspect, cke}, 16'h0006, 0);
		issue(dct_pkg::DCT_OP_INIT, 2'h0, 16'h0000, t0);
		wait_flag(0, 16'h0000);
		cmp({14'h0, needInit, dataSuspect}, 16'h0001, 0);
		issue(dct_pkg::DCT_OP_SRX, 2'h0, 16'h0000, t0);
		repeat (8) @(negedge clock);
		cmp({14'h0, needInit, cke}, 16'h0002, 0);
		$display("illegal operation done");
	endtask

	initial begin
		repeat (8) @(negedge clock);
		rstn = 1;
		wait_flag(0, 16'h0000);
		cmp({14'h0, needInit, cke}, 16'h0001, 0);
		t_write_read();
		t_recovery();
		t_self_refresh();
		t_illegal();
		cmp(16'(violations), 16'h0000, 0);
		close_out();
	end
endmodule
